//--- dic_pkg.sv
// Package with register map, field layout, reset values and timing for the input conditioner.
package dic_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] DIC_CTRL_OFS  = 8'h00;
  localparam logic [7:0] DIC_DEB_OFS   = 8'h04;
  localparam logic [7:0] DIC_PRIO_OFS  = 8'h08;
  localparam logic [7:0] DIC_STAT_OFS  = 8'h0c;
  localparam logic [7:0] DIC_IRQS_OFS  = 8'h10;
  localparam logic [7:0] DIC_IRQM_OFS  = 8'h14;
  localparam logic [7:0] DIC_COUNT_OFS = 8'h18;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int DIC_CTRL_MODE_LSB = 0;
  localparam int DIC_CTRL_POL_BIT  = 2;
  localparam int DIC_CTRL_LOG_BIT  = 3;
  localparam int DIC_CTRL_EN_BIT   = 4;
  localparam int DIC_CTRL_ALM_BIT  = 5;

  // ----------------------------------------
  // Status and interrupt fields
  // ----------------------------------------
  localparam int DIC_STAT_STATE_BIT = 0;
  localparam int DIC_STAT_ALARM_BIT = 1;
  localparam int DIC_STAT_BASE_BIT  = 2;
  localparam int DIC_IRQ_TRIG_BIT   = 0;
  localparam int DIC_IRQ_LOG_BIT    = 1;
  localparam int DIC_IRQ_REJ_BIT    = 2;
  localparam int DIC_IRQ_WIDTH      = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0]  DIC_CTRL_RST = 6'h10;
  localparam logic [9:0]  DIC_DEB_RST  = 10'h000;
  localparam logic [7:0]  DIC_PRIO_RST = 8'h00;
  localparam logic [2:0]  DIC_IRQ_RST  = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DIC_CLK_HZ        = 20_000_000;
  localparam int DIC_DEB_MAX_MS    = 1000;
  localparam int DIC_MS_PER_S      = 1000;
  localparam int DIC_CYC_PER_MS    = DIC_CLK_HZ / DIC_MS_PER_S;
  localparam int DIC_AC_HOLD_MS    = 40;
  localparam int DIC_AC_HOLD_CYC   = DIC_AC_HOLD_MS * DIC_CYC_PER_MS;

  // Input processing modes.
  typedef enum logic [1:0]
  {
    DIC_MODE_PULSE = 2'b00,
    DIC_MODE_BOTH  = 2'b01,
    DIC_MODE_AC    = 2'b10,
    DIC_MODE_IRIG  = 2'b11
  } dic_mode_t;

endpackage

//--- dic_cfg_if.sv
// Interface carrying configuration and conditioned results between conditioner modules.
`timescale 1ns/1ps
interface dic_cfg_if;
  import dic_pkg::*;

  logic      polarity_invert;
  logic [9:0] debounce_ms;
  logic      state;
  logic      state_rise;
  logic      state_fall;

  modport ctrl
  (
    output polarity_invert,
    output debounce_ms,
    input  state,
    input  state_rise,
    input  state_fall
  );

  modport filt
  (
    input  polarity_invert,
    input  debounce_ms,
    output state,
    output state_rise,
    output state_fall
  );
endinterface

//--- dic_debounce.sv
// Polarity stage and debounce filter that produces the conditioned state and its edges.
`timescale 1ns/1ps
module dic_debounce
  import dic_pkg::*;
#(
  parameter int CYC_PER_MS = DIC_CYC_PER_MS
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level_in,
  dic_cfg_if.filt   cfg
);

  logic        cand_reg;
  logic        state_reg;
  logic [15:0] tick_reg;
  logic [9:0]  ms_reg;
  logic        lvl;
  logic        tick_done;

  // Optional inversion ahead of detection.
  assign lvl       = level_in ^ cfg.polarity_invert;
  assign tick_done = (tick_reg == 16'(CYC_PER_MS - 1));

  // Millisecond timer restarts whenever the level differs from the candidate.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cand_reg <= 1'b0;
      tick_reg <= 16'h0000;
      ms_reg   <= 10'h000;
    end
    else if (lvl != cand_reg)
    begin
      cand_reg <= lvl;
      tick_reg <= 16'h0000;
      ms_reg   <= 10'h000;
    end
    else if (cand_reg != state_reg && ms_reg < cfg.debounce_ms)
    begin
      tick_reg <= tick_done ? 16'h0000 : tick_reg + 16'h0001;
      if (tick_done)
      begin
        ms_reg <= ms_reg + 10'h001;
      end
    end
    else
    begin
      tick_reg <= 16'h0000;
      ms_reg   <= 10'h000;
    end
  end

  // Accept the candidate once it has stood for the debounce time.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= 1'b0;
      cfg.state_rise <= 1'b0;
      cfg.state_fall <= 1'b0;
    end
    else
    begin
      cfg.state_rise <= 1'b0;
      cfg.state_fall <= 1'b0;
      if (lvl == cand_reg && cand_reg != state_reg && ms_reg >= cfg.debounce_ms)
      begin
        state_reg      <= cand_reg;
        cfg.state_rise <= cand_reg;
        cfg.state_fall <= ~cand_reg;
      end
    end
  end

  assign cfg.state = state_reg;

endmodule

//--- dic_ac_detect.sv
// Retriggerable detector that reports presence of an alternating signal.
`timescale 1ns/1ps
module dic_ac_detect
  import dic_pkg::*;
#(
  parameter int HOLD_CYC = DIC_AC_HOLD_CYC
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      present
);

  logic        last_reg;
  logic [23:0] hold_reg;

  // Every level change reloads the hold timer; present while it runs.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      last_reg <= 1'b0;
      hold_reg <= 24'h000000;
    end
    else
    begin
      last_reg <= level_in;
      if (last_reg != level_in)
      begin
        hold_reg <= 24'(HOLD_CYC);
      end
      else if (hold_reg != 24'h000000)
      begin
        hold_reg <= hold_reg - 24'h000001;
      end
    end
  end

  assign present = (hold_reg != 24'h000000);

endmodule

//--- dic_top.sv
// Digital input conditioner: polarity, debounce, mode edges, alarm, events and Wishbone registers.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module dic_top
  import dic_pkg::*;
#(
  parameter bit BASE_UNIT  = 1'b1,
  parameter int CYC_PER_MS = DIC_CYC_PER_MS,
  parameter int AC_HOLD    = DIC_AC_HOLD_CYC
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        din,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             trigger,
  output logic             state_out,
  output logic             alarm,
  output logic             timesync_out,
  output logic             event_valid,
  output logic [7:0]       event_priority,
  output logic             event_state,
  output logic             irq
);

  // ----------------------------------------
  // Registers and internal signals
  // ----------------------------------------
  dic_mode_t   mode_reg;
  logic        pol_reg;
  logic        log_reg;
  logic        en_reg;
  logic        alm_on_reg;
  logic [9:0]  deb_reg;
  logic [7:0]  prio_reg;
  logic [2:0]  irqs_reg;
  logic [2:0]  irqm_reg;
  logic [31:0] count_reg;
  logic        ac_prev_reg;
  logic        wr_stb;
  logic        rd_stb;
  logic        mode_rej;
  logic        ac_present;
  logic        cond_state;
  logic        edge_on;
  logic        edge_off;
  logic        trig_next;
  logic        evt_next;
  logic [2:0]  irq_set;
  logic [31:0] rd_data;
  logic [31:0] deb_wr;

  dic_cfg_if cfg_bus ();

  // Byte-lane merge used by the debounce register write.
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Conditioning stages
  // ----------------------------------------
  assign cfg_bus.polarity_invert = pol_reg;
  assign cfg_bus.debounce_ms     = deb_reg;

  dic_debounce #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_deb (
    .clock    (clock),
    .rst      (rst),
    .level_in (din),
    .cfg      (cfg_bus.filt)
  );

  dic_ac_detect #(
    .HOLD_CYC (AC_HOLD)
  ) u_ac (
    .clock    (clock),
    .rst      (rst),
    .level_in (din ^ pol_reg),
    .present  (ac_present)
  );

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  assign wr_stb   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  // Time-sync selection refused on an expansion channel.
  assign mode_rej = wr_stb && wb_adr_i == DIC_CTRL_OFS && wb_sel_i[0] && !BASE_UNIT
                    && dic_mode_t'(wb_dat_i[DIC_CTRL_MODE_LSB +: 2]) == DIC_MODE_IRIG;

  // Control register writes.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_reg   <= dic_mode_t'(DIC_CTRL_RST[DIC_CTRL_MODE_LSB +: 2]);
      pol_reg    <= DIC_CTRL_RST[DIC_CTRL_POL_BIT];
      log_reg    <= DIC_CTRL_RST[DIC_CTRL_LOG_BIT];
      en_reg     <= DIC_CTRL_RST[DIC_CTRL_EN_BIT];
      alm_on_reg <= DIC_CTRL_RST[DIC_CTRL_ALM_BIT];
    end
    else if (wr_stb && wb_adr_i == DIC_CTRL_OFS && wb_sel_i[0])
    begin
      if (!mode_rej)
      begin
        mode_reg <= dic_mode_t'(wb_dat_i[DIC_CTRL_MODE_LSB +: 2]);
      end
      pol_reg    <= wb_dat_i[DIC_CTRL_POL_BIT];
      log_reg    <= wb_dat_i[DIC_CTRL_LOG_BIT];
      en_reg     <= wb_dat_i[DIC_CTRL_EN_BIT];
      alm_on_reg <= wb_dat_i[DIC_CTRL_ALM_BIT];
    end
  end

  // Debounce write value after the byte-lane merge, kept out of the clocked process.
  assign deb_wr = wb_merge({22'h000000, deb_reg}, wb_dat_i, wb_sel_i);

  // Debounce time in milliseconds, clamped to one second.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      deb_reg <= DIC_DEB_RST;
    end
    else if (wr_stb && wb_adr_i == DIC_DEB_OFS)
    begin
      deb_reg <= (deb_wr > 32'(DIC_DEB_MAX_MS)) ? 10'(DIC_DEB_MAX_MS) : deb_wr[9:0];
    end
  end

  // Event priority value.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prio_reg <= DIC_PRIO_RST;
    end
    else if (wr_stb && wb_adr_i == DIC_PRIO_OFS && wb_sel_i[0])
    begin
      prio_reg <= wb_dat_i[7:0];
    end
  end

  // Interrupt mask.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irqm_reg <= DIC_IRQ_RST;
    end
    else if (wr_stb && wb_adr_i == DIC_IRQM_OFS && wb_sel_i[0])
    begin
      irqm_reg <= wb_dat_i[DIC_IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // Mode handling and edge generation
  // ----------------------------------------
  // In AC mode the state follows presence directly, so a trigger lands with its state change.
  assign cond_state = (mode_reg == DIC_MODE_AC) ? ac_present : cfg_bus.state;
  assign edge_on    = (mode_reg == DIC_MODE_AC) ? (ac_present & ~ac_prev_reg)
                                                : cfg_bus.state_rise;
  assign edge_off   = (mode_reg == DIC_MODE_AC) ? (~ac_present & ac_prev_reg)
                                                : cfg_bus.state_fall;

  // Trigger and event decisions per mode.
  always_comb
  begin
    trig_next = 1'b0;
    case (mode_reg)
      DIC_MODE_PULSE: trig_next = edge_on;
      DIC_MODE_BOTH:  trig_next = edge_on | edge_off;
      DIC_MODE_AC:    trig_next = edge_on;
      DIC_MODE_IRIG:  trig_next = 1'b0;
      default:        trig_next = 1'b0;
    endcase
    trig_next = trig_next & en_reg;
    evt_next  = (edge_on | edge_off) & en_reg & log_reg
                & (mode_reg != DIC_MODE_IRIG);
  end

  // Previous AC presence, used to form its edges.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ac_prev_reg <= 1'b0;
    end
    else
    begin
      ac_prev_reg <= ac_present;
    end
  end

  // Registered outputs.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      trigger        <= 1'b0;
      state_out      <= 1'b0;
      alarm          <= 1'b0;
      timesync_out   <= 1'b0;
      event_valid    <= 1'b0;
      event_priority <= 8'h00;
      event_state    <= 1'b0;
    end
    else
    begin
      trigger      <= trig_next;
      state_out    <= cond_state;
      alarm        <= en_reg & (alm_on_reg ? cond_state : ~cond_state);
      timesync_out <= (mode_reg == DIC_MODE_IRIG) & en_reg & (din ^ pol_reg);
      event_valid  <= evt_next;
      if (evt_next)
      begin
        event_priority <= prio_reg;
        event_state    <= edge_on;
      end
    end
  end

  // Trigger counter, readable by software.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= 32'h00000000;
    end
    else if (wr_stb && wb_adr_i == DIC_COUNT_OFS)
    begin
      count_reg <= 32'h00000000;
    end
    else if (trig_next)
    begin
      count_reg <= count_reg + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------
  assign irq_set = {mode_rej, evt_next, trig_next};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irqs_reg <= DIC_IRQ_RST;
    end
    else if (wr_stb && wb_adr_i == DIC_IRQS_OFS && wb_sel_i[0])
    begin
      irqs_reg <= (irqs_reg & ~wb_dat_i[DIC_IRQ_WIDTH-1:0]) | irq_set;
    end
    else
    begin
      irqs_reg <= irqs_reg | irq_set;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irqs_reg & irqm_reg);
    end
  end

  // ----------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------
  always_comb
  begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      DIC_CTRL_OFS:  rd_data = {26'h0000000, alm_on_reg, en_reg, log_reg, pol_reg, mode_reg};
      DIC_DEB_OFS:   rd_data = {22'h000000, deb_reg};
      DIC_PRIO_OFS:  rd_data = {24'h000000, prio_reg};
      DIC_STAT_OFS:  rd_data = {29'h00000000, BASE_UNIT, alarm, state_out};
      DIC_IRQS_OFS:  rd_data = {29'h00000000, irqs_reg};
      DIC_IRQM_OFS:  rd_data = {29'h00000000, irqm_reg};
      DIC_COUNT_OFS: rd_data = count_reg;
      default:       rd_data = 32'h00000000;
    endcase
  end

  // One wait state: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_stb ? rd_data : 32'h00000000;
    end
  end

endmodule

//--- dic_contact_model.sv
// Model of an external contact that bounces on each change and can carry an AC signal.
`timescale 1ns/1ps
module dic_contact_model
(
  input  wire logic       clock,
  input  wire logic       target,
  input  wire logic       ac_on,
  input  wire logic [3:0] bounces,
  output logic            din
);
  logic       din_reg  = 1'b0;
  logic       tgt_reg  = 1'b0;
  logic [3:0] left_reg = 4'h0;
  logic [1:0] cnt_reg  = 2'h0;

  assign din = din_reg;

  // ----------------------------------------
  // Contact behaviour
  // ----------------------------------------
  // A new target starts a burst of bounces, each four cycles long, before the contact settles.
  // While the AC source is on, the line toggles every four cycles.
  always_ff @(posedge clock)
  begin
    cnt_reg <= cnt_reg + 2'h1;
    if (target != tgt_reg)
    begin
      tgt_reg  <= target;
      left_reg <= bounces;
    end
    else if (cnt_reg == 2'h3)
    begin
      if (ac_on)
        din_reg <= ~din_reg;
      else if (left_reg != 4'h0)
      begin
        din_reg  <= ~din_reg;
        left_reg <= left_reg - 4'h1;
      end
      else
        din_reg <= tgt_reg;
    end
  end
endmodule

//--- dic_top_properties.sv
// Concurrent checks on the ports of the input conditioner.
`timescale 1ns/1ps
module dic_top_properties
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        trigger,
  input wire logic        state_out,
  input wire logic        timesync_out,
  input wire logic        event_valid,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Bus and output checks
  // ----------------------------------------
  AST_RST_QUIET: assert property ($past(rst) |-> !trigger && !irq && !state_out && !wb_ack_o)
    else $error("output active right after reset");
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RD_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_TRIG_EDGE: assert property (trigger |-> state_out != $past(state_out))
    else $error("trigger without state change");
  AST_TRIG_ONE: assert property (trigger |=> !trigger)
    else $error("trigger longer than one cycle");
  AST_SYNC_QUIET: assert property (timesync_out |-> !trigger && !event_valid)
    else $error("trigger or event in time-sync mode");
  AST_EVT_ONE: assert property (event_valid |=> !event_valid)
    else $error("event longer than one cycle");
endmodule

bind dic_top dic_top_properties chk_u (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger(trigger),
  .state_out(state_out), .timesync_out(timesync_out), .event_valid(event_valid), .irq(irq));

//--- testbench.sv
// Self-checking testbench for the digital input conditioner.
`timescale 1ns/1ps
module testbench;
  import dic_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic        target = 1'b0;
  logic        ac_on = 1'b0;
  logic [3:0]  bounces = 4'h0;
  logic [31:0] wb_dat_o, wb_dat_x, last_qx;
  logic        wb_ack_o, trigger, state_out, alarm, timesync_out;
  logic        event_valid, event_state, irq, din, last_evst;
  logic [7:0]  event_priority, last_prio;
  int          fails = 0;
  int          total_checks = 0;
  int          trig_n = 0;
  int          evt_n = 0;
  int          t0, e0;

  dic_contact_model cm_u (.clock(clock), .target(target), .ac_on(ac_on), .bounces(bounces),
    .din(din));
  dic_top #(.CYC_PER_MS(4), .AC_HOLD(50)) dut_u (.clock(clock), .rst(rst), .din(din),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trigger(trigger), .state_out(state_out), .alarm(alarm), .timesync_out(timesync_out),
    .event_valid(event_valid), .event_priority(event_priority), .event_state(event_state),
    .irq(irq));
  // Expansion channel on the same bus and input; only its read data is watched.
  dic_top #(.BASE_UNIT(1'b0), .CYC_PER_MS(4), .AC_HOLD(50)) dut_x (.clock(clock), .rst(rst),
    .din(din), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_x), .wb_ack_o(), .trigger(),
    .state_out(), .alarm(), .timesync_out(), .event_valid(), .event_priority(),
    .event_state(), .irq());

  // Clock generator, 50 ns period.
  initial forever #25 clock = ~clock;

  // Counts trigger pulses and logged events, keeping the last event's fields.
  always @(posedge clock)
  begin
    if (trigger === 1'b1) trig_n++;
    if (event_valid === 1'b1)
    begin
      evt_n++;
      last_prio = event_priority;
      last_evst = event_state;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; held until ack is sampled, then released for a cycle.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hf;
    do begin @(posedge clock); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    last_qx = wb_dat_x;
    if (wb_ack_o !== 1'b1) begin fails++; finish_test(); end
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    @(posedge clock);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Waits, bounded, for the conditioned state, then lets trailing pulses land.
  task wait_state(input logic e);
    int n;
    n = 0;
    while (state_out !== e && n < 400) begin @(posedge clock); n++; end
    if (n >= 400) begin fails++; finish_test(); end
    repeat (4) @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    rd_chk(DIC_CTRL_OFS, 32'h10);
    rd_chk(DIC_DEB_OFS, 32'h0);
    rd_chk(DIC_PRIO_OFS, 32'h0);
    rd_chk(DIC_IRQM_OFS, 32'h0);
    rd_chk(DIC_STAT_OFS, 32'h6);
    wr(8'h1c, 32'hffff_ffff);
    rd_chk(8'h1c, 32'h0);
    $display("test regs done");
  endtask

  task t_pulse();
    wr(DIC_CTRL_OFS, 32'h18); wr(DIC_DEB_OFS, 32'h2); wr(DIC_PRIO_OFS, 32'hff);
    wr(DIC_COUNT_OFS, 32'h0);
    t0 = trig_n; e0 = evt_n;
    bounces <= 4'h4; target <= 1'b1;
    wait_state(1'b1);
    chk(32'(trig_n - t0), 32'h1);
    chk({24'h0, last_prio}, 32'hff);
    chk({31'h0, last_evst}, 32'h1);
    rd_chk(DIC_STAT_OFS, 32'h5);
    target <= 1'b0;
    wait_state(1'b0);
    chk(32'(trig_n - t0), 32'h1);
    chk(32'(evt_n - e0), 32'h2);
    rd_chk(DIC_COUNT_OFS, 32'h1);
    $display("test pulse done");
  endtask

  task t_both();
    bounces <= 4'h0;
    wr(DIC_CTRL_OFS, 32'h19); wr(DIC_IRQS_OFS, 32'h7);
    t0 = trig_n;
    target <= 1'b1; wait_state(1'b1);
    target <= 1'b0; wait_state(1'b0);
    chk(32'(trig_n - t0), 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(DIC_IRQM_OFS, 32'h1); repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(DIC_IRQS_OFS, 32'h1); repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test both-edge done");
  endtask

  task t_pol();
    e0 = evt_n;
    wr(DIC_CTRL_OFS, 32'h34);
    wait_state(1'b1);
    chk({31'h0, alarm}, 32'h1);
    rd_chk(DIC_STAT_OFS, 32'h7);
    chk(32'(evt_n - e0), 32'h0);
    wr(DIC_CTRL_OFS, 32'h14); repeat (3) @(posedge clock);
    chk({31'h0, alarm}, 32'h0);
    $display("test polarity done");
  endtask

  task t_dis();
    wr(DIC_CTRL_OFS, 32'h08);
    t0 = trig_n; e0 = evt_n;
    target <= 1'b1; repeat (60) @(posedge clock);
    target <= 1'b0; repeat (60) @(posedge clock);
    chk(32'(trig_n - t0), 32'h0);
    chk(32'(evt_n - e0), 32'h0);
    $display("test disable done");
  endtask

  task t_ac();
    wr(DIC_DEB_OFS, 32'h0); wr(DIC_CTRL_OFS, 32'h12);
    ac_on <= 1'b1; wait_state(1'b1);
    chk({31'h0, state_out}, 32'h1);
    ac_on <= 1'b0; wait_state(1'b0);
    chk({31'h0, state_out}, 32'h0);
    $display("test ac done");
  endtask

  task t_sync();
    wr(DIC_CTRL_OFS, 32'h13);
    t0 = trig_n;
    target <= 1'b1; repeat (20) @(posedge clock);
    chk({31'h0, timesync_out}, 32'h1);
    target <= 1'b0; repeat (20) @(posedge clock);
    chk({31'h0, timesync_out}, 32'h0);
    chk(32'(trig_n - t0), 32'h0);
    rd_chk(DIC_CTRL_OFS, 32'h13);
    chk(last_qx, 32'h12);
    rd_chk(DIC_IRQS_OFS, 32'h3);
    chk(last_qx, 32'h7);
    $display("test time-sync done");
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_pulse();
    t_both();
    t_pol();
    t_dis();
    t_ac();
    t_sync();
    finish_test();
  end
endmodule
